// file: rtl/gsp_defines.vh
// register indices, field positions, reset values and bus codes of the port block
`ifndef GSP_DEFINES_VH
`define GSP_DEFINES_VH

// *****************************************************************
// register indices (byte address is four times the index)
// *****************************************************************
`define GSP_IDX_SER_DATA      8'h24
`define GSP_IDX_SER_ODE       8'h25
`define GSP_IDX_SER_DIR       8'h26
`define GSP_IDX_SER_FUNC      8'h27
`define GSP_IDX_PUP_DATA      8'h28
`define GSP_IDX_TMR_DATA      8'h29
`define GSP_IDX_TMR_DIR       8'h2a
`define GSP_IDX_TMR_FUNC      8'h2b

// *****************************************************************
// widths and reset values
// *****************************************************************
`define GSP_SER_W             3
`define GSP_PUP_W             4
`define GSP_TMR_W             5
`define GSP_SER_LATCH_RST     3'h7
`define GSP_SER_DIR_RST       3'h0
`define GSP_SER_FUNC_RST      3'h0
`define GSP_SER_ODE_RST       3'h0
`define GSP_TMR_LATCH_RST     5'h00
`define GSP_TMR_DIR_RST       5'h00
`define GSP_TMR_FUNC_RST      5'h00

// *****************************************************************
// serial port field positions
// *****************************************************************
`define GSP_SER_CLK_BIT       0
`define GSP_SER_DOUT_BIT      1
`define GSP_SER_DIN_BIT       2

// *****************************************************************
// timer port: pin index inside the 5-bit group; the data word puts pins 0 to 4 on bits 0, 1, 3, 5 and 6
// *****************************************************************
`define GSP_TMR_PIN_T0IN      0
`define GSP_TMR_PIN_IRQ1      1
`define GSP_TMR_PIN_IRQ0      2
`define GSP_TMR_PIN_IRQ2      3
`define GSP_TMR_PIN_IRQ3      4

// *****************************************************************
// axi response codes
// *****************************************************************
`define GSP_RESP_OKAY         2'h0
`define GSP_RESP_SLVERR       2'h2

`endif

// file: rtl/gsp_top.v
// general-purpose port block: serial-capable, pull-up input and timer/interrupt pin groups behind axi4-lite
`timescale 1ns/10ps
`default_nettype none
`include "gsp_defines.vh"

// How it works
// RULE1: the serial port data word reads pins on bits 0 to 2, is writable there, and its output latch resets to ones.
// RULE2: serial direction and function-select registers reset to zero so every serial pin starts as an input.
// RULE3: serial function bit 0 low keeps a port pin that feeds serial clock in, high drives the serial clock out.
// RULE4: serial function bit 1 low is a plain port, high drives serial data out or the two-wire data line.
// RULE5: serial function bit 2 low keeps a port pin that feeds serial data in, high joins the two-wire clock line.
// RULE6: software using serial data in or serial clock in leaves function bits 2 and 0 at zero.
// RULE7: software does no read-modify-write on the write-only serial control registers, which read as zero.
// RULE8: the pull-up port has pull-ups and a read-only word returning live pins on bits 7, 2, 1 and 0.
// RULE9: the timer port has five pins, each set as input or output on its own.
// RULE10: timer port direction and function registers reset to zero, so all its pins start as inputs.
// RULE11: setting matching direction and function bits routes a timer pin to its timer or interrupt role.
// RULE12: the timer port roles are one timer input, three timer outputs and interrupt inputs 0 to 3.
// RULE13: timer port pin 0 also feeds the external input of timer channel 0.
// RULE14: timer port pin 0 has no function bit and always feeds timer channel 0, even as a port input.
// RULE15: a timer port pin in output mode reads back its pin level, never the output latch.
// RULE16: each serial open-drain bit makes that pin's driver open-drain when set and push-pull when clear.
module gsp_top #(
    parameter ADDR_W = 8
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // serial-capable pins (pin 0 clock, pin 1 data out, pin 2 data in)
    input wire [`GSP_SER_W-1:0] ser_pin_in,
    output wire [`GSP_SER_W-1:0] ser_pin_out,
    output wire [`GSP_SER_W-1:0] ser_pin_oe,
    // serial unit side
    input wire serial_clock_out,
    input wire serial_data_out,
    input wire two_wire_mode,
    input wire two_wire_data_out,
    input wire two_wire_clock_out,
    output wire serial_clock_in,
    output wire serial_data_in,
    output wire two_wire_data_in,
    output wire two_wire_clock_in,
    // pull-up input pins (bits 0, 1, 2 and 7 of the data word)
    input wire [`GSP_PUP_W-1:0] pup_pin_in,
    output wire [`GSP_PUP_W-1:0] pup_pullup_en,
    // timer/interrupt pins
    input wire [`GSP_TMR_W-1:0] tmr_pin_in,
    output wire [`GSP_TMR_W-1:0] tmr_pin_out,
    output wire [`GSP_TMR_W-1:0] tmr_pin_oe,
    // timer and interrupt unit side
    input wire timer1_output,
    input wire timer3_output,
    input wire wide_timer0_output0,
    output wire timer0_external_input,
    output wire ext_irq_input_0,
    output wire ext_irq_input_1,
    output wire ext_irq_input_2,
    output wire ext_irq_input_3
);

    // *****************************************************************
    // pin synchronisers
    // *****************************************************************
    reg [`GSP_SER_W-1:0] ser_meta_q;
    reg [`GSP_SER_W-1:0] ser_sync_q;
    reg [`GSP_PUP_W-1:0] pup_meta_q;
    reg [`GSP_PUP_W-1:0] pup_sync_q;
    reg [`GSP_TMR_W-1:0] tmr_meta_q;
    reg [`GSP_TMR_W-1:0] tmr_sync_q;

    // every pin passes two flops; only the second stage is read
    always @(posedge aclk) begin
        if (!aresetn) begin
            ser_meta_q <= 3'h0;
            ser_sync_q <= 3'h0;
            pup_meta_q <= 4'h0;
            pup_sync_q <= 4'h0;
            tmr_meta_q <= 5'h00;
            tmr_sync_q <= 5'h00;
        end else begin
            ser_meta_q <= ser_pin_in;
            ser_sync_q <= ser_meta_q;
            pup_meta_q <= pup_pin_in;
            pup_sync_q <= pup_meta_q;
            tmr_meta_q <= tmr_pin_in;
            tmr_sync_q <= tmr_meta_q;
        end
    end

    // *****************************************************************
    // configuration registers
    // *****************************************************************
    reg [`GSP_SER_W-1:0] ser_latch_q;
    reg [`GSP_SER_W-1:0] ser_dir_q;
    reg [`GSP_SER_W-1:0] ser_func_q;
    reg [`GSP_SER_W-1:0] ser_ode_q;
    reg [`GSP_TMR_W-1:0] tmr_latch_q;
    reg [`GSP_TMR_W-1:0] tmr_dir_q;
    reg [`GSP_TMR_W-1:0] tmr_func_q;

    // *****************************************************************
    // axi4-lite write channel
    // *****************************************************************
    reg aw_have_q;
    reg w_have_q;
    reg [ADDR_W-1:0] aw_addr_q;
    reg [7:0] w_byte_q;
    reg w_lane0_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    wire [7:0] wr_idx;
    wire wr_fire;
    reg wr_hit;

    // address and data are taken in either order; one write at a time
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign wr_idx = {{(10-ADDR_W){1'b0}}, aw_addr_q[ADDR_W-1:2]};
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

    // decode of the held write address; the pull-up word is mapped but read-only
    always @* begin
        case (wr_idx)
            `GSP_IDX_SER_DATA, `GSP_IDX_SER_ODE, `GSP_IDX_SER_DIR, `GSP_IDX_SER_FUNC,
            `GSP_IDX_PUP_DATA, `GSP_IDX_TMR_DATA, `GSP_IDX_TMR_DIR, `GSP_IDX_TMR_FUNC: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    // capture the two halves of a write, then answer once both are held
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= {ADDR_W{1'b0}};
            w_byte_q <= 8'h00;
            w_lane0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `GSP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_byte_q <= s_axi_wdata[7:0];
                w_lane0_q <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `GSP_RESP_OKAY : `GSP_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // register updates; only byte lane 0 carries data, other lanes are ignored
    always @(posedge aclk) begin
        if (!aresetn) begin
            ser_latch_q <= `GSP_SER_LATCH_RST; // [RULE1]
            ser_dir_q <= `GSP_SER_DIR_RST; // [RULE2]
            ser_func_q <= `GSP_SER_FUNC_RST; // [RULE2]
            ser_ode_q <= `GSP_SER_ODE_RST;
            tmr_latch_q <= `GSP_TMR_LATCH_RST;
            tmr_dir_q <= `GSP_TMR_DIR_RST; // [RULE10]
            tmr_func_q <= `GSP_TMR_FUNC_RST; // [RULE10]
        end else if (wr_fire && w_lane0_q) begin
            case (wr_idx)
                `GSP_IDX_SER_DATA: begin
                    ser_latch_q <= w_byte_q[2:0]; // [RULE1]
                end
                `GSP_IDX_SER_ODE: begin
                    ser_ode_q <= w_byte_q[2:0]; // [RULE16]
                end
                `GSP_IDX_SER_DIR: begin
                    ser_dir_q <= w_byte_q[2:0];
                end
                `GSP_IDX_SER_FUNC: begin
                    ser_func_q <= w_byte_q[2:0];
                end
                `GSP_IDX_TMR_DATA: begin
                    tmr_latch_q <= {w_byte_q[6], w_byte_q[5], w_byte_q[3], w_byte_q[1], w_byte_q[0]};
                end
                `GSP_IDX_TMR_DIR: begin
                    tmr_dir_q <= {w_byte_q[6], w_byte_q[5], w_byte_q[3], w_byte_q[1], w_byte_q[0]}; // [RULE9]
                end
                `GSP_IDX_TMR_FUNC: begin
                    tmr_func_q <= {w_byte_q[6], w_byte_q[5], w_byte_q[3], w_byte_q[1], w_byte_q[0]}; // [RULE11]
                end
                default: begin
                    ser_latch_q <= ser_latch_q;
                end
            endcase
        end
    end

    // *****************************************************************
    // axi4-lite read channel
    // *****************************************************************
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;
    reg [7:0] rd_byte;
    reg rd_hit;
    wire [7:0] rd_idx;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign rd_idx = {{(10-ADDR_W){1'b0}}, s_axi_araddr[ADDR_W-1:2]};

    // read mux; control registers cannot be read back, so software must keep its own copy
    always @* begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        case (rd_idx)
            `GSP_IDX_SER_DATA: begin
                rd_byte = {5'h00, ser_sync_q}; // [RULE1]
            end
            `GSP_IDX_SER_ODE, `GSP_IDX_SER_DIR, `GSP_IDX_SER_FUNC,
            `GSP_IDX_TMR_DIR, `GSP_IDX_TMR_FUNC: begin
                rd_byte = 8'h00; // [RULE7]
            end
            `GSP_IDX_PUP_DATA: begin
                rd_byte = {pup_sync_q[3], 4'h0, pup_sync_q[2:0]}; // [RULE8]
            end
            `GSP_IDX_TMR_DATA: begin
                // pins read in every mode, so an output never shows its latch
                rd_byte = {1'b0, tmr_sync_q[4], tmr_sync_q[3], 1'b0, tmr_sync_q[2], 1'b0,
                           tmr_sync_q[1], tmr_sync_q[0]}; // [RULE15]
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // one read at a time; the answer follows the address by one cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `GSP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= {24'h000000, rd_byte};
            rresp_q <= rd_hit ? `GSP_RESP_OKAY : `GSP_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // *****************************************************************
    // serial-capable pin group
    // *****************************************************************
    reg [`GSP_SER_W-1:0] ser_val;
    reg [`GSP_SER_W-1:0] ser_out_q;
    reg [`GSP_SER_W-1:0] ser_oe_q;
    integer i;

    // pick latch or alternate source per pin; the direction bit still gates the driver
    always @* begin
        ser_val = ser_latch_q;
        if (ser_func_q[`GSP_SER_CLK_BIT])
            ser_val[`GSP_SER_CLK_BIT] = serial_clock_out; // [RULE3]
        if (ser_func_q[`GSP_SER_DOUT_BIT])
            ser_val[`GSP_SER_DOUT_BIT] = two_wire_mode ? two_wire_data_out : serial_data_out; // [RULE4]
        if (ser_func_q[`GSP_SER_DIN_BIT])
            ser_val[`GSP_SER_DIN_BIT] = two_wire_clock_out; // [RULE5]
    end

    // registered drivers; open-drain drives low only and releases for a high
    always @(posedge aclk) begin
        if (!aresetn) begin
            ser_out_q <= 3'h0;
            ser_oe_q <= 3'h0;
        end else begin
            for (i = 0; i < `GSP_SER_W; i = i + 1) begin
                if (ser_ode_q[i]) begin
                    ser_out_q[i] <= 1'b0; // [RULE16]
                    ser_oe_q[i] <= ser_dir_q[i] && !ser_val[i]; // [RULE16]
                end else begin
                    ser_out_q[i] <= ser_val[i];
                    ser_oe_q[i] <= ser_dir_q[i];
                end
            end
        end
    end

    assign ser_pin_out = ser_out_q;
    assign ser_pin_oe = ser_oe_q;
    // inputs to the serial unit idle high while the pin is switched to another role
    assign serial_clock_in = ser_func_q[`GSP_SER_CLK_BIT] ? 1'b1 : ser_sync_q[`GSP_SER_CLK_BIT]; // [RULE3]
    assign serial_data_in = ser_func_q[`GSP_SER_DIN_BIT] ? 1'b1 : ser_sync_q[`GSP_SER_DIN_BIT]; // [RULE5]
    assign two_wire_data_in = ser_func_q[`GSP_SER_DOUT_BIT] ? ser_sync_q[`GSP_SER_DOUT_BIT] : 1'b1; // [RULE4]
    assign two_wire_clock_in = ser_func_q[`GSP_SER_DIN_BIT] ? ser_sync_q[`GSP_SER_DIN_BIT] : 1'b1; // [RULE5]

    // *****************************************************************
    // pull-up input pin group
    // *****************************************************************
    // pull-ups are always on; there is no control to turn them off
    assign pup_pullup_en = {`GSP_PUP_W{1'b1}}; // [RULE8]

    // *****************************************************************
    // timer/interrupt pin group
    // *****************************************************************
    reg [`GSP_TMR_W-1:0] tmr_val;
    reg [`GSP_TMR_W-1:0] tmr_out_q;
    reg [`GSP_TMR_W-1:0] tmr_oe_q;
    wire [`GSP_TMR_W-1:0] tmr_alt_in;

    // function plus output routes the timer outputs; pin 0 and the irq0 pin have no timer output
    always @* begin
        tmr_val = tmr_latch_q;
        if (tmr_func_q[`GSP_TMR_PIN_IRQ1])
            tmr_val[`GSP_TMR_PIN_IRQ1] = timer1_output; // [RULE11] [RULE12]
        if (tmr_func_q[`GSP_TMR_PIN_IRQ2])
            tmr_val[`GSP_TMR_PIN_IRQ2] = timer3_output; // [RULE11] [RULE12]
        if (tmr_func_q[`GSP_TMR_PIN_IRQ3])
            tmr_val[`GSP_TMR_PIN_IRQ3] = wide_timer0_output0; // [RULE11] [RULE12]
    end

    // each pin drives only when its own direction bit is set
    always @(posedge aclk) begin
        if (!aresetn) begin
            tmr_out_q <= 5'h00;
            tmr_oe_q <= 5'h00;
        end else begin
            tmr_out_q <= tmr_val;
            tmr_oe_q <= tmr_dir_q; // [RULE9]
        end
    end

    assign tmr_pin_out = tmr_out_q;
    assign tmr_pin_oe = tmr_oe_q;
    // interrupt role is function set with the pin kept as input
    assign tmr_alt_in = tmr_func_q & ~tmr_dir_q & tmr_sync_q; // [RULE11]
    assign ext_irq_input_0 = tmr_alt_in[`GSP_TMR_PIN_IRQ0]; // [RULE12]
    assign ext_irq_input_1 = tmr_alt_in[`GSP_TMR_PIN_IRQ1]; // [RULE12]
    assign ext_irq_input_2 = tmr_alt_in[`GSP_TMR_PIN_IRQ2]; // [RULE12]
    assign ext_irq_input_3 = tmr_alt_in[`GSP_TMR_PIN_IRQ3]; // [RULE12]
    // no gating here: the timer sees this pin in every mode
    assign timer0_external_input = tmr_sync_q[`GSP_TMR_PIN_T0IN]; // [RULE13] [RULE14]

endmodule // gsp_top

`default_nettype wire

// file: dv/gsp_pin_model.sv
// pin-side model: resolves each pin from the block's drive and the outside level
`timescale 1ns/10ps
`default_nettype none
module gsp_pin_model #(
    parameter int W = 3
) (
    // block drive
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    // outside world
    input wire logic [W-1:0] ext_level,
    output logic [W-1:0] pin_level
);
    // an enabled driver wins; a released pin shows what the outside puts there
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // gsp_pin_model
`default_nettype wire

// file: dv/gsp_top_props.sv
// concurrent checks on the port block's ports
`timescale 1ns/10ps
`default_nettype none
module gsp_top_props (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    // serial pins
    input wire logic [2:0] ser_pin_in,
    input wire logic [2:0] ser_pin_oe,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    input wire logic two_wire_clock_in,
    // pull-up and timer pins
    input wire logic [3:0] pup_pullup_en,
    input wire logic [4:0] tmr_pin_in,
    input wire logic [4:0] tmr_pin_oe,
    input wire logic timer0_external_input,
    input wire logic ext_irq_input_0,
    input wire logic ext_irq_input_3
);
    logic [1:0] warm_q;
    logic [1:0] warm_d;
    logic warm;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // synchronisers need two edges after reset before $past compares are meaningful
    assign warm_d = (warm_q == 2'h3) ? warm_q : warm_q + 2'h1;
    assign warm = (warm_q == 2'h3);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            warm_q <= 2'h0;
        end else begin
            warm_q <= warm_d;
        end
    end
    chk_rst_inputs: assert property ($rose(aresetn) |-> ser_pin_oe == 3'h0 && tmr_pin_oe == 5'h00)
        else $error("pins driving right after reset");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
        else $error("read answer late or upper bits set");
    chk_read_single: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
        else $error("read answer without a taken address");
    chk_pullup_on: assert property (pup_pullup_en == 4'hf)
        else $error("pull-ups not enabled");
    chk_timer0_follow: assert property (warm |-> timer0_external_input == $past(tmr_pin_in[0], 2))
        else $error("timer channel 0 input does not follow its pin");
    chk_clock_in_idle: assert property (warm && serial_clock_in != $past(ser_pin_in[0], 2) |-> serial_clock_in)
        else $error("serial clock input neither pin nor idle");
    chk_pin2_one_user: assert property (warm && !$past(ser_pin_in[2], 2) |-> serial_data_in ^ two_wire_clock_in)
        else $error("data-in pin feeds both or neither unit");
    chk_irq_from_pin: assert property (warm && (ext_irq_input_0 || ext_irq_input_3)
        |-> (!ext_irq_input_0 || $past(tmr_pin_in[2], 2)) && (!ext_irq_input_3 || $past(tmr_pin_in[4], 2)))
        else $error("interrupt input high without its pin");
    chk_dir_by_write: assert property (warm && !$stable(tmr_pin_oe) |-> $past(s_axi_bvalid))
        else $error("timer pin direction changed without a write");
    cov_irq0: cover property (ext_irq_input_0);
    cov_open_drain: cover property (ser_pin_oe == 3'h5);
    cov_all_out: cover property (tmr_pin_oe == 5'h1f);
endmodule // gsp_top_props
bind gsp_top gsp_top_props u_gsp_top_props (.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
    .s_axi_bvalid(s_axi_bvalid), .ser_pin_in(ser_pin_in), .ser_pin_oe(ser_pin_oe), .serial_clock_in(serial_clock_in),
    .serial_data_in(serial_data_in), .two_wire_clock_in(two_wire_clock_in), .pup_pullup_en(pup_pullup_en),
    .tmr_pin_in(tmr_pin_in), .tmr_pin_oe(tmr_pin_oe), .timer0_external_input(timer0_external_input),
    .ext_irq_input_0(ext_irq_input_0), .ext_irq_input_3(ext_irq_input_3));
`default_nettype wire

// file: dv/tb.sv
// self-checking testbench for the port block
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic awready, wready, bvalid, arready, rvalid, sci, sdi, twdi, twci, t0i;
    logic [2:0] ser_in, ser_out, ser_oe, ser_ext = 0;
    logic [4:0] tmr_in, tmr_out, tmr_oe, tmr_ext = 0;
    logic [3:0] pup_ext = 0, pup_en, irq;
    logic sco = 0, sdo = 0, twm = 0, twdo = 0, twco = 0, t1o = 0, t3o = 0, wt0o = 0;
    int fail_count = 0, n_compared = 0;
    // 10 MHz clock
    always #50 aclk = ~aclk;
    gsp_top u_gsp_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ser_pin_in(ser_in), .ser_pin_out(ser_out), .ser_pin_oe(ser_oe),
        .serial_clock_out(sco), .serial_data_out(sdo), .two_wire_mode(twm), .two_wire_data_out(twdo),
        .two_wire_clock_out(twco), .serial_clock_in(sci), .serial_data_in(sdi), .two_wire_data_in(twdi),
        .two_wire_clock_in(twci), .pup_pin_in(pup_ext), .pup_pullup_en(pup_en), .tmr_pin_in(tmr_in),
        .tmr_pin_out(tmr_out), .tmr_pin_oe(tmr_oe), .timer1_output(t1o), .timer3_output(t3o),
        .wide_timer0_output0(wt0o), .timer0_external_input(t0i), .ext_irq_input_0(irq[0]),
        .ext_irq_input_1(irq[1]), .ext_irq_input_2(irq[2]), .ext_irq_input_3(irq[3]));
    gsp_pin_model #(.W(3)) u_gsp_pin_model (.pin_out(ser_out), .pin_oe(ser_oe), .ext_level(ser_ext),
        .pin_level(ser_in));
    gsp_pin_model #(.W(5)) u_gsp_pin_model_tmr (.pin_out(tmr_out), .pin_oe(tmr_oe), .ext_level(tmr_ext),
        .pin_level(tmr_in));
    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // pins pass two sync flops; allow four edges
    task automatic settle();
        repeat (4) @(posedge aclk);
    endtask
    // one write, both channels offered together
    task automatic axi_write(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic a, w, ad, wd;
        n = 0;
        {ad, wd} = 2'b00;
        @(posedge aclk);
        awaddr <= {idx[5:0], 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            a = awvalid && awready;
            w = wvalid && wready;
            n++;
            @(posedge aclk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            ad = ad | a;
            wd = wd | w;
        end while (!(ad && wd) && n < 50);
        do begin
            @(negedge aclk);
            n++;
        end while (!bvalid && n < 50);
        cmp(bresp, er);
        @(posedge aclk);
        bready <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            end_of_test();
        end
    endtask
    task automatic axi_read(input logic [7:0] idx);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= {idx[5:0], 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            n++;
        end while (!arready && n < 50);
        @(posedge aclk);
        arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            n++;
        end while (!rvalid && n < 50);
        rd = rdata;
        rs = rresp;
        @(posedge aclk);
        rready <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            end_of_test();
        end
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_ser_port();
        cmp(ser_oe, 3'h0);
        cmp(tmr_oe, 5'h00);
        axi_write(8'h26, 32'h7, 2'h0);
        settle();
        axi_read(8'h24);
        cmp(rd, 32'h7);
        axi_write(8'h24, 32'h2, 2'h0);
        settle();
        axi_read(8'h24);
        cmp(rd, 32'h2);
        axi_write(8'h25, 32'h7, 2'h0);
        settle();
        cmp({ser_oe, ser_out}, 6'b101000);
        axi_write(8'h25, 32'h0, 2'h0);
        settle();
        cmp({ser_oe, ser_out}, 6'b111010);
    endtask
    task automatic t_ser_func();
        sco <= 1'b1;
        sdo <= 1'b1;
        twco <= 1'b1;
        axi_write(8'h27, 32'h7, 2'h0);
        settle();
        cmp(ser_out, 3'b111);
        twm <= 1'b1;
        settle();
        cmp(ser_out, 3'b101);
        axi_write(8'h26, 32'h0, 2'h0);
        settle();
        cmp({sci, sdi, twci, twdi}, 4'b1100);
        axi_write(8'h27, 32'h0, 2'h0);
        settle();
        cmp({sci, sdi, twci, twdi}, 4'b0011);
    endtask
    task automatic t_pullup();
        pup_ext <= 4'b1010;
        settle();
        axi_read(8'h28);
        cmp(rd, 32'h82);
        cmp(pup_en, 4'hf);
        axi_write(8'h28, 32'hff, 2'h0);
        axi_read(8'h28);
        cmp(rd, 32'h82);
    endtask
    task automatic t_timer();
        tmr_ext <= 5'b01111;
        settle();
        axi_read(8'h29);
        cmp(rd, 32'h2b);
        cmp(t0i, 1'b1);
        cmp(irq, 4'h0);
        axi_write(8'h2b, 32'h6b, 2'h0);
        settle();
        cmp(irq, 4'b0111);
        t1o <= 1'b1;
        wt0o <= 1'b1;
        axi_write(8'h29, 32'h6a, 2'h0);
        axi_write(8'h2a, 32'h6b, 2'h0);
        settle();
        cmp({tmr_oe, tmr_out}, 10'b11111_10110);
        cmp(irq, 4'h0);
        cmp(t0i, 1'b0);
        axi_read(8'h29);
        cmp(rd, 32'h4a);
    endtask
    task automatic t_unmapped();
        axi_write(8'h30, 32'h1, 2'h2);
        axi_read(8'h30);
        cmp(rs, 2'h2);
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        t_ser_port();
        t_ser_func();
        t_pullup();
        t_timer();
        t_unmapped();
        end_of_test();
    end
endmodule // tb
`default_nettype wire
